// *** verilog/mode_reg_pkg.sv ***
package mode_reg_pkg;

    // Mode register addresses on the 6-bit address field
    localparam logic [5:0] ADDR_SEGMENT_MASK = 6'h11;
    localparam logic [5:0] ADDR_OSC_LOW      = 6'h12;
    localparam logic [5:0] ADDR_OSC_HIGH     = 6'h13;
    localparam logic [5:0] ADDR_UB_INVERT    = 6'h14;

    localparam logic [7:0] SEGMENT_MASK_RESET = 8'h00;
    localparam logic [7:0] UB_INVERT_RESET    = 8'h55;
    localparam logic [15:0] OSC_COUNT_RESET   = 16'h0000;

    localparam int OSC_LOW_LSB  = 0;
    localparam int OSC_HIGH_LSB = 8;

    // Per-channel density codes
    localparam logic [2:0] DENS_1G  = 3'h0;
    localparam logic [2:0] DENS_2G  = 3'h1;
    localparam logic [2:0] DENS_3G  = 3'h2;
    localparam logic [2:0] DENS_4G  = 3'h3;
    localparam logic [2:0] DENS_6G  = 3'h4;
    localparam logic [2:0] DENS_8G  = 3'h5;
    localparam logic [2:0] DENS_12G = 3'h6;
    localparam logic [2:0] DENS_16G = 3'h7;

    // Lowest row bit of the segment field for the 1Gb density
    localparam int SEG_LSB_1G = 11;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] data;
    } mr_cmd_s;

    typedef struct packed {
        logic [7:0] dq;
        logic       dmi;
    } cal_lane_s;

endpackage

// *** verilog/segment_decode.sv ***
`timescale 1ns/1ns
module segment_decode (
    input  wire logic [17:0] i_row,
    input  wire logic [2:0]  i_density,
    input  wire logic [7:0]  i_mask,
    output logic             o_blocked
);
    logic [4:0] lsb;
    logic [2:0] segment;

    always_comb begin
        // From 3Gb upward each density pair shares one row field
        case (i_density)
            mode_reg_pkg::DENS_1G: begin
                lsb = 5'(mode_reg_pkg::SEG_LSB_1G);
            end
            mode_reg_pkg::DENS_2G: begin
                lsb = 5'(mode_reg_pkg::SEG_LSB_1G + 1);
            end
            mode_reg_pkg::DENS_3G, mode_reg_pkg::DENS_4G: begin
                lsb = 5'(mode_reg_pkg::SEG_LSB_1G + 2);
            end
            mode_reg_pkg::DENS_6G, mode_reg_pkg::DENS_8G: begin
                lsb = 5'(mode_reg_pkg::SEG_LSB_1G + 3);
            end
            default: begin
                lsb = 5'(mode_reg_pkg::SEG_LSB_1G + 4);
            end
        endcase
        segment = 3'(i_row >> lsb);
        o_blocked = i_mask[segment];
    end
endmodule

// *** verilog/cal_invert.sv ***
`timescale 1ns/1ns
module cal_invert (
    input  wire logic [7:0]            i_pattern,
    input  wire logic                  i_dmi_pattern,
    input  wire logic [7:0]            i_invert,
    output mode_reg_pkg::cal_lane_s    o_lane
);
    always_comb begin
        o_lane.dq  = i_pattern ^ i_invert;
        o_lane.dmi = i_dmi_pattern;
    end
endmodule

// *** verilog/dram_mode_reg_subset.sv ***
`timescale 1ns/1ns
// Functional notes
// - Segment mask bits reset to zero; a one disables refresh of that segment.
// - Mask bit n selects segment n, three top row bits by density.
// - Each channel holds its own segment mask.
// - Oscillator-low register returns count bits 7:0 on read.
// - Oscillator-high register returns count bits 15:8 on read.
// - Oscillator start command clears both count registers.
// - Each set invert bit inverts the calibration pattern on its upper DQ.
// - Upper-byte invert register is write-only, reset value 0x55.
// - Invert bits 0..3 map DQ8..11, bits 4..7 map DQ12..15.
// - Upper DMI line carries the true pattern, never inverted.
// - No bus inversion during read calibration, whatever the configuration.
module dram_mode_reg_subset (
    input  wire logic                    i_clk,
    input  wire logic                    i_rst_n,
    input  wire logic                    i_channel,
    input  mode_reg_pkg::mr_cmd_s        i_cmd,
    output logic                         o_rd_valid,
    output logic [7:0]                   o_rd_data,
    input  wire logic                    i_osc_start,
    input  wire logic                    i_osc_tick,
    input  wire logic [2:0]              i_density,
    input  wire logic                    i_ref_channel,
    input  wire logic [17:0]             i_ref_row,
    output logic                         o_ref_blocked,
    input  wire logic                    i_cal_active,
    input  wire logic                    i_dbi_enable,
    input  wire logic [15:0]             i_cal_pattern,
    input  wire logic [1:0]              i_dmi_pattern,
    output logic [15:0]                  o_cal_dq,
    output logic [1:0]                   o_cal_dmi,
    output logic                         o_dbi_active
);
    logic [7:0]  seg_mask [2];
    logic [7:0]  next_seg_mask [2];
    logic [7:0]  ub_invert;
    logic [7:0]  next_ub_invert;
    logic [15:0] osc_count;
    logic [15:0] next_osc_count;
    logic        next_rd_valid;
    logic [7:0]  next_rd_data;
    logic [15:0] next_cal_dq;
    logic [1:0]  next_cal_dmi;
    logic        ub_blocked;
    logic        next_ref_blocked;
    logic        next_dbi_active;
    logic [7:0]  sel_mask;
    mode_reg_pkg::cal_lane_s upper_lane;

    function automatic logic hit(input mode_reg_pkg::mr_cmd_s c, input logic [5:0] a);
        hit = c.addr == a;
    endfunction

    always_comb begin
        next_seg_mask[0] = seg_mask[0];
        next_seg_mask[1] = seg_mask[1];
        next_ub_invert   = ub_invert;
        if (i_cmd.wr && hit(i_cmd, mode_reg_pkg::ADDR_SEGMENT_MASK)) begin
            next_seg_mask[i_channel] = i_cmd.data;
        end
        if (i_cmd.wr && hit(i_cmd, mode_reg_pkg::ADDR_UB_INVERT)) begin
            next_ub_invert = i_cmd.data;
        end
    end

    always_comb begin
        next_osc_count = osc_count;
        if (i_osc_start) begin
            next_osc_count = mode_reg_pkg::OSC_COUNT_RESET;
        end else if (i_osc_tick && osc_count != 16'hFFFF) begin
            next_osc_count = osc_count + 16'h0001;
        end
    end

    always_comb begin
        next_rd_valid = i_cmd.rd;
        next_rd_data  = 8'h00;
        if (i_cmd.rd) begin
            case (i_cmd.addr)
                mode_reg_pkg::ADDR_OSC_LOW: begin
                    next_rd_data = osc_count[mode_reg_pkg::OSC_LOW_LSB +: 8];
                end
                mode_reg_pkg::ADDR_OSC_HIGH: begin
                    next_rd_data = osc_count[mode_reg_pkg::OSC_HIGH_LSB +: 8];
                end
                default: begin
                    next_rd_data = 8'h00;
                end
            endcase
        end
    end

    assign sel_mask = seg_mask[i_ref_channel];

    segment_decode u_segment_decode (
        .i_row     (i_ref_row),
        .i_density (i_density),
        .i_mask    (sel_mask),
        .o_blocked (ub_blocked)
    );

    cal_invert u_cal_invert (
        .i_pattern     (i_cal_pattern[15:8]),
        .i_dmi_pattern (i_dmi_pattern[1]),
        .i_invert      (ub_invert),
        .o_lane        (upper_lane)
    );

    always_comb begin
        next_ref_blocked = ub_blocked;
    end

    always_comb begin
        next_cal_dq     = 16'h0000;
        next_cal_dmi    = 2'b00;
        next_dbi_active = i_dbi_enable && !i_cal_active;
        if (i_cal_active) begin
            next_cal_dq[15:8] = upper_lane.dq;
            next_cal_dq[7:0]  = i_cal_pattern[7:0];
            next_cal_dmi      = {upper_lane.dmi, i_dmi_pattern[0]};
        end
    end

    // Segment masks and invert register
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            seg_mask[0] <= mode_reg_pkg::SEGMENT_MASK_RESET;
            seg_mask[1] <= mode_reg_pkg::SEGMENT_MASK_RESET;
            ub_invert   <= mode_reg_pkg::UB_INVERT_RESET;
        end else begin
            seg_mask    <= next_seg_mask;
            ub_invert   <= next_ub_invert;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            osc_count <= mode_reg_pkg::OSC_COUNT_RESET;
        end else begin
            osc_count <= next_osc_count;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rd_valid <= 1'b0;
            o_rd_data  <= 8'h00;
        end else begin
            o_rd_valid <= next_rd_valid;
            o_rd_data  <= next_rd_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_ref_blocked <= 1'b0;
        end else begin
            o_ref_blocked <= next_ref_blocked;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_cal_dq     <= 16'h0000;
            o_cal_dmi    <= 2'b00;
            o_dbi_active <= 1'b0;
        end else begin
            o_cal_dq     <= next_cal_dq;
            o_cal_dmi    <= next_cal_dmi;
            o_dbi_active <= next_dbi_active;
        end
    end
endmodule

// *** tb/mr_ctrl_model.sv ***
`timescale 1ns/1ns
module mr_ctrl_model (
    input  wire logic             i_clk,
    input  wire logic             i_rd_valid,
    input  wire logic [7:0]       i_rd_data,
    output mode_reg_pkg::mr_cmd_s o_cmd,
    output logic                  o_channel
);
    initial o_cmd = '0;
    initial o_channel = 1'b0;
    task automatic mr_wr(input logic ch, input logic [5:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_channel = ch;
        o_cmd = {2'b10, a, d};
        @(negedge i_clk);
        o_cmd = '0;
    endtask
    task automatic mr_rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge i_clk);
        o_cmd = {2'b01, a, 8'h00};
        @(negedge i_clk);
        o_cmd = '0;
        d = i_rd_valid ? i_rd_data : 8'hxx;
    endtask
    // High byte above low byte
    task automatic osc_count(output logic [15:0] c);
        mr_rd(6'h12, c[7:0]);
        mr_rd(6'h13, c[15:8]);
    endtask
endmodule

// *** tb/dram_mode_reg_subset_props.sv ***
`timescale 1ns/1ns
module dram_mode_reg_subset_props (
    input wire logic             i_clk,
    input wire logic             i_rst_n,
    input mode_reg_pkg::mr_cmd_s i_cmd,
    input wire logic             o_rd_valid,
    input wire logic [7:0]       o_rd_data,
    input wire logic             i_osc_start,
    input wire logic             i_osc_tick,
    input wire logic             i_cal_active,
    input wire logic [15:0]      i_cal_pattern,
    input wire logic [1:0]       i_dmi_pattern,
    input wire logic [15:0]      o_cal_dq,
    input wire logic [1:0]       o_cal_dmi,
    input wire logic             o_dbi_active
);
    logic [7:0] inv;
    always_ff @(posedge i_clk) begin
        inv <= !i_rst_n ? 8'h55 : (i_cmd.wr && i_cmd.addr == 6'h14) ? i_cmd.data : inv;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    chk_rd_answer: assert property (i_cmd.rd |=> o_rd_valid) else $error("no answer");
    chk_rd_quiet: assert property (!i_cmd.rd |=> !o_rd_valid) else $error("stray valid");
    chk_wo_zero: assert property (i_cmd.rd && i_cmd.addr == 6'h14 |=> o_rd_data == 8'h00) else $error("wo");
    chk_unmapped_zero: assert property (i_cmd.rd && i_cmd.addr > 6'h14 |=> o_rd_data == 8'h00) else $error("map");
    chk_osc_cleared: assert property ((i_osc_start ##1 (!i_osc_start && !i_osc_tick) ##1 i_cmd.rd)
        |=> o_rd_data == 8'h00) else $error("count kept");
    chk_dmi_true: assert property (i_cal_active |=> o_cal_dmi == $past(i_dmi_pattern)) else $error("dmi");
    chk_dbi_off: assert property (i_cal_active |=> !o_dbi_active) else $error("dbi on");
    chk_ub_invert: assert property (i_cal_active |=> o_cal_dq[15:8] == ($past(i_cal_pattern[15:8]) ^ $past(inv)))
        else $error("invert");
endmodule
bind dram_mode_reg_subset dram_mode_reg_subset_props u_props (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd(i_cmd),
    .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .i_osc_start(i_osc_start), .i_osc_tick(i_osc_tick),
    .i_cal_active(i_cal_active),
    .i_cal_pattern(i_cal_pattern), .i_dmi_pattern(i_dmi_pattern), .o_cal_dq(o_cal_dq), .o_cal_dmi(o_cal_dmi),
    .o_dbi_active(o_dbi_active));

// *** tb/tb_dram_mode_reg_subset.sv ***
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; $display("Error %s exp %h got %h", n, e, g); end end
module tb_dram_mode_reg_subset;
    logic                  clk = 1'b0;
    logic                  rst_n, chan, start, tick, ref_ch, cal, dbi, rd_valid, blocked, dbi_act;
    logic [2:0]            dens;
    logic [17:0]           row;
    logic [15:0]           pat, cal_dq, cnt;
    logic [1:0]            dmi, cal_dmi;
    logic [7:0]            rd_data, rd;
    mode_reg_pkg::mr_cmd_s cmd;
    int                    errors = 0, n_compared = 0, cycles = 0;
    int                    lsb[8] = '{11, 12, 13, 13, 14, 14, 15, 15};
    always #2 clk = ~clk;
    dram_mode_reg_subset u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_channel(chan), .i_cmd(cmd), .o_rd_valid(rd_valid),
        .o_rd_data(rd_data), .i_osc_start(start), .i_osc_tick(tick), .i_density(dens), .i_ref_channel(ref_ch),
        .i_ref_row(row), .o_ref_blocked(blocked), .i_cal_active(cal), .i_dbi_enable(dbi), .i_cal_pattern(pat),
        .i_dmi_pattern(dmi), .o_cal_dq(cal_dq), .o_cal_dmi(cal_dmi), .o_dbi_active(dbi_act));
    mr_ctrl_model u_ctrl (.i_clk(clk), .i_rd_valid(rd_valid), .i_rd_data(rd_data), .o_cmd(cmd), .o_channel(chan));
    task automatic summarize();
        $display("Compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk) if (++cycles == 3000) begin
        errors++;
        summarize();
    end
    task automatic query(input logic c, input logic [17:0] r, input logic e);
        @(negedge clk);
        ref_ch = c;
        row = r;
        @(negedge clk);
        `CHK("blocked", e, blocked)
    endtask
    task automatic cal_check(input logic [15:0] p, input logic [1:0] m, input logic [15:0] e);
        @(negedge clk);
        {cal, dbi, pat, dmi} = {2'b11, p, m};
        @(negedge clk);
        `CHK("cal_dq", e, cal_dq)
        `CHK("cal_dmi", m, cal_dmi)
        `CHK("dbi", 1'b0, dbi_act)
        cal = 1'b0;
    endtask
    initial begin
        {rst_n, start, tick, ref_ch, cal, dbi, dens, row, pat, dmi} = '0;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        query(1'b0, 18'h0, 1'b0);
        u_ctrl.mr_rd(6'h14, rd);
        `CHK("invert_read", 8'h00, rd)
        u_ctrl.mr_rd(6'h3F, rd);
        `CHK("unmapped", 8'h00, rd)
        cal_check(16'h0000, 2'b11, 16'h5500);
        @(negedge clk);
        `CHK("cal_idle", 16'h0000, cal_dq)
        `CHK("dmi_idle", 2'b00, cal_dmi)
        `CHK("dbi_idle", 1'b1, dbi_act)
        u_ctrl.mr_wr(1'b0, 6'h14, 8'h15);
        cal_check(16'hFFFF, 2'b10, 16'hEAFF);
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        tick = 1'b1;
        repeat (300) @(negedge clk);
        tick = 1'b0;
        u_ctrl.osc_count(cnt);
        `CHK("osc_count", 16'h012C, cnt)
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        u_ctrl.osc_count(cnt);
        `CHK("osc_cleared", 16'h0000, cnt)
        u_ctrl.mr_wr(1'b0, 6'h11, 8'h20);
        u_ctrl.mr_wr(1'b1, 6'h11, 8'h01);
        for (int d = 0; d < 8; d++) begin
            dens = 3'(d);
            query(1'b0, 18'h5 << lsb[d], 1'b1);
            query(1'b0, 18'h4 << lsb[d], 1'b0);
            query(1'b1, 18'h5 << lsb[d], 1'b0);
            query(1'b1, 18'h0, 1'b1);
        end
        u_ctrl.mr_wr(1'b0, 6'h11, 8'h00);
        query(1'b0, 18'h5 << lsb[7], 1'b0);
        summarize();
    end
endmodule
